// >>> hw/cbc_irq_gate.sv
// general interrupt request sampling and enable gate
`timescale 1ns/10ps
module cbc_irq_gate
  import cbc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic general_irq_request_i,
  input wire logic sample_win_i,
  input wire logic irq_enable_set_i,
  input wire logic irq_enable_clr_i,
  output logic irq_accept_o,
  output logic irq_enabled_o
);
  logic en_q;
  logic en_d;
  logic acc_q;
  logic acc_d;

  always_comb begin
    acc_d = sample_win_i & general_irq_request_i & en_q; // [R14]
    en_d = en_q;
    if (irq_enable_clr_i) begin
      en_d = 1'b0;
    end
    if (irq_enable_set_i) begin
      en_d = 1'b1;
    end
    if (acc_d) begin
      en_d = 1'b0; // [R17]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      en_q <= 1'b0; // [R17]
      acc_q <= 1'b0;
    end else begin
      en_q <= en_d;
      acc_q <= acc_d;
    end
  end

  assign irq_accept_o = acc_q;
  assign irq_enabled_o = en_q;

  accept_clears_en_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R17]
    acc_d |=> !en_q)
    else $error("enable not cleared after accept");
  accept_window_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R14]
    acc_q |-> $past(sample_win_i) && $past(en_q))
    else $error("interrupt accepted outside sample window");
endmodule

// >>> hw/cbc_pkg.sv
// package for the cpu bus cycle, hold and interrupt control block
// Overview of operation
// [R1] drive read strobe low so addressed device places data on bus
// [R2] read strobe floats in hold, halt and reset
// [R3] drive write strobe low so bus data is written to location
// [R4] write data stays valid through rising edge of write strobe
// [R5] write strobe floats in hold and halt
// [R6] memory or peripheral raises ready once it can transfer data
// [R7] cycle stretched by whole clocks while ready low
// [R8] on hold request release buses after current transfer completes
// [R9] internal work may continue during hold without bus transfers
// [R10] buses taken back only after hold request withdrawn
// [R11] in hold, address, data, strobes and io select float
// [R12] grant ack asserted once hold accepted; bus released next cycle
// [R13] ack drops after request removed; bus driven half cycle later
// [R14] irq sampled only next-to-last instruction cycle, hold or halt
// [R15] accepted irq freezes program counter and issues acknowledge strobe
// [R16] interrupting device supplies restart or call during acknowledge
// [R17] irq acceptance disabled on reset and after acceptance; software re-enables
// [R18] acknowledge strobe replaces read strobe with same timing in fetch
package cbc_pkg;
  localparam int CBC_AW = 16;
  localparam int CBC_DW = 8;
  // kinds of transfer: read, write, fetch (acknowledge strobe while irq pending)
  typedef enum logic [1:0] {
    CBC_OP_READ,
    CBC_OP_WRITE,
    CBC_OP_FETCH
  } cbc_op_t;
  typedef struct packed {
    logic [CBC_AW-1:0] addr;
    logic [CBC_DW-1:0] wdata;
    logic io_sel;
    cbc_op_t op;
  } cbc_req_t;
  typedef struct packed {
    logic [CBC_AW-1:0] addr;
    logic [CBC_DW-1:0] data;
    logic io_sel;
    logic rd_n;
    logic wr_n;
    logic ack_n;
  } cbc_bus_t;
  localparam cbc_bus_t CBC_BUS_IDLE = '{addr: 16'h0000, data: 8'h00, io_sel: 1'b0,
                                        rd_n: 1'b1, wr_n: 1'b1, ack_n: 1'b1};
  localparam logic [1:0] CBC_HALF_CYC = 2'h1;
endpackage

// >>> hw/cbc_top.sv
// bus cycle, wait, hold and interrupt acknowledge control
`timescale 1ns/10ps
module cbc_top
  import cbc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire cbc_req_t req_i,
  input wire logic last_cyc_next_i,
  input wire logic halt_i,
  input wire logic irq_enable_set_i,
  input wire logic irq_enable_clr_i,
  input wire logic ready_i,
  input wire logic hold_req_i,
  input wire logic general_irq_request_i,
  input wire logic [CBC_DW-1:0] data_in_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [CBC_DW-1:0] rdata_o,
  output logic pc_inhibit_o,
  output logic irq_enabled_o,
  output cbc_bus_t bus_o,
  output logic addr_oe_o,
  output logic data_oe_o,
  output logic ctrl_oe_o,
  output logic bus_grant_ack_o
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    CBC_IDLE,
    CBC_ADDR,
    CBC_STROBE,
    CBC_END,
    CBC_HOLD,
    CBC_RESUME
  } cbc_state_t;

  cbc_state_t st_q, st_d;
  cbc_req_t cur_q, cur_d;
  cbc_bus_t bus_q, bus_d;
  logic aoe_q, aoe_d, doe_q, doe_d, coe_q, coe_d;
  logic ack_q, ack_d, done_q, done_d, rdy_q, rdy_d;
  logic pend_q, pend_d, inh_q, inh_d;
  logic [CBC_DW-1:0] rdata_q, rdata_d;
  logic [1:0] half_q, half_d;
  logic irq_acc;
  logic irq_en;
  logic sample_win;

  // sampling allowed near instruction end, in hold or in halt
  assign sample_win = last_cyc_next_i | (st_q == CBC_HOLD) | halt_i; // [R14]

  cbc_irq_gate cbc_irq_gate_i (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .general_irq_request_i(general_irq_request_i),
    .sample_win_i(sample_win),
    .irq_enable_set_i(irq_enable_set_i),
    .irq_enable_clr_i(irq_enable_clr_i),
    .irq_accept_o(irq_acc),
    .irq_enabled_o(irq_en)
  );

  function automatic cbc_bus_t strobe_on(input cbc_req_t r, input logic pend);
    cbc_bus_t b;
    b = '{addr: r.addr, data: r.wdata, io_sel: r.io_sel, rd_n: 1'b1, wr_n: 1'b1,
          ack_n: 1'b1};
    if (r.op == CBC_OP_WRITE) begin
      b.wr_n = 1'b0; // [R3]
    end else if (r.op == CBC_OP_FETCH && pend) begin
      b.ack_n = 1'b0; // [R18]
    end else begin
      b.rd_n = 1'b0; // [R1]
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    bus_d = bus_q;
    aoe_d = aoe_q;
    doe_d = doe_q;
    coe_d = coe_q;
    ack_d = ack_q;
    done_d = 1'b0;
    rdy_d = 1'b0;
    rdata_d = rdata_q;
    half_d = half_q;
    pend_d = pend_q | irq_acc;
    inh_d = inh_q | irq_acc; // [R15]
    case (st_q)
      CBC_IDLE: begin
        // halted: strobes float, internal work may go on
        coe_d = ~halt_i; // [R2] [R5]
        aoe_d = ~halt_i;
        doe_d = 1'b0;
        bus_d.rd_n = 1'b1;
        bus_d.wr_n = 1'b1;
        bus_d.ack_n = 1'b1;
        if (hold_req_i) begin
          ack_d = 1'b1; // [R8] [R12]
          st_d = CBC_HOLD;
        end else if (req_valid_i && !halt_i) begin
          cur_d = req_i;
          bus_d.addr = req_i.addr;
          bus_d.io_sel = req_i.io_sel;
          aoe_d = 1'b1;
          coe_d = 1'b1;
          st_d = CBC_ADDR;
        end else begin
          rdy_d = ~halt_i;
        end
      end
      CBC_ADDR: begin
        bus_d = strobe_on(cur_q, pend_q);
        doe_d = (cur_q.op == CBC_OP_WRITE);
        st_d = CBC_STROBE;
      end
      CBC_STROBE: begin
        // strobe held whole cycles until ready seen high
        if (ready_i) begin // [R7]
          rdata_d = data_in_i;
          bus_d.rd_n = 1'b1;
          bus_d.wr_n = 1'b1; // [R4]
          bus_d.ack_n = 1'b1;
          st_d = CBC_END;
        end
      end
      CBC_END: begin
        // write data kept one more cycle past the strobe rising edge
        doe_d = 1'b0; // [R4]
        done_d = 1'b1;
        // a new accept in this very cycle must survive the clear
        if (cur_q.op == CBC_OP_FETCH && pend_q) begin
          pend_d = irq_acc;
          inh_d = irq_acc; // [R15]
        end
        st_d = CBC_IDLE;
      end
      CBC_HOLD: begin // [R9]
        // all bus lines float from the cycle after the grant; core requests wait, core runs on
        aoe_d = 1'b0; // [R11]
        doe_d = 1'b0;
        coe_d = 1'b0; // [R2] [R5]
        if (!hold_req_i) begin
          ack_d = 1'b0; // [R10] [R13]
          half_d = CBC_HALF_CYC;
          st_d = CBC_RESUME;
        end
      end
      CBC_RESUME: begin
        // half bus cycle counted in core clocks before the lines are driven again
        if (half_q == 2'h0) begin
          aoe_d = 1'b1; // [R13]
          coe_d = 1'b1;
          st_d = CBC_IDLE;
        end else begin
          half_d = half_q - 2'h1;
        end
      end
      default: begin
        st_d = CBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= CBC_IDLE;
      cur_q <= '0;
      bus_q <= CBC_BUS_IDLE;
      aoe_q <= 1'b0; // [R2]
      doe_q <= 1'b0;
      coe_q <= 1'b0;
      ack_q <= 1'b0;
      done_q <= 1'b0;
      rdy_q <= 1'b0;
      rdata_q <= 8'h00;
      half_q <= 2'h0;
      pend_q <= 1'b0;
      inh_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      bus_q <= bus_d;
      aoe_q <= aoe_d;
      doe_q <= doe_d;
      coe_q <= coe_d;
      ack_q <= ack_d;
      done_q <= done_d;
      rdy_q <= rdy_d;
      rdata_q <= rdata_d;
      half_q <= half_d;
      pend_q <= pend_d;
      inh_q <= inh_d;
    end
  end

  // irq_en leaves the gate register directly
  assign irq_enabled_o = irq_en; // [R17]
  assign bus_o = bus_q;
  assign addr_oe_o = aoe_q;
  assign data_oe_o = doe_q;
  assign ctrl_oe_o = coe_q;
  assign bus_grant_ack_o = ack_q;
  assign done_o = done_q;
  assign req_ready_o = rdy_q;
  assign rdata_o = rdata_q;
  assign pc_inhibit_o = inh_q;

  //////////////////////////////////////////////////////////////////////////////
  sequence strobe_low_s;
    !bus_q.rd_n || !bus_q.wr_n || !bus_q.ack_n;
  endsequence

  wait_hold_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R7]
    (st_q == CBC_STROBE && !ready_i) |=> ((st_q == CBC_STROBE) and strobe_low_s))
    else $error("strobe released while not ready");
  hold_float_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R11]
    (st_q == CBC_HOLD) |=> (ack_q || st_q == CBC_RESUME) && !aoe_q && !coe_q
      && !doe_q)
    else $error("bus driven during hold");
  grant_after_xfer_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R8]
    $rose(ack_q) |-> $past(st_q) == CBC_IDLE)
    else $error("grant given mid transfer");
  grant_keep_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R10]
    (ack_q && hold_req_i) |=> ack_q)
    else $error("bus taken back while hold requested");
  resume_drive_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R13]
    $fell(ack_q) |-> !coe_q ##1 !coe_q ##1 coe_q)
    else $error("bus not retaken after grant drop");
  write_data_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R4]
    $rose(bus_q.wr_n) |-> doe_q && $stable(bus_q.data))
    else $error("write data not held at strobe rise");
  ack_not_rd_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R18]
    !bus_q.ack_n |-> bus_q.rd_n && pend_q)
    else $error("acknowledge and read strobe together");
  pc_freeze_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R15]
    irq_acc |=> pc_inhibit_o)
    else $error("program counter not frozen");
  halt_float_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R2]
    (halt_i && st_q == CBC_IDLE && !hold_req_i) |=> !coe_q)
    else $error("strobes driven in halt");
endmodule

// >>> sim/cbc_mem_model.sv
// memory and peripheral model answering the bus cycles of the control block
`timescale 1ns/10ps
module cbc_mem_model
  import cbc_pkg::*;
#(
  parameter logic [7:0] RESTART_OP = 8'h5a // arbitrary opcode value
)
(
  input wire logic core_clk_i,
  input wire logic [3:0] wait_cyc_i,
  input wire cbc_bus_t bus_i,
  input wire logic ctrl_oe_i,
  output logic ready_o,
  output logic [CBC_DW-1:0] data_o
);
  logic [3:0] cnt_q;
  logic strobe;
  initial begin
    cnt_q = 4'h0;
    ready_o = 1'b0;
    data_o = 8'ha5;
  end
  assign strobe = ctrl_oe_i && !(bus_i.rd_n && bus_i.wr_n && bus_i.ack_n);
  always @(posedge core_clk_i) begin
    if (!strobe) begin
      cnt_q <= 4'h0;
      ready_o <= 1'b0;
      // a released bus must not look like it still holds the last byte
      data_o <= ~data_o;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      ready_o <= (cnt_q >= wait_cyc_i);
      data_o <= !bus_i.ack_n ? RESTART_OP : (bus_i.addr[7:0] ^ 8'h3c);
    end
  end
endmodule

// >>> sim/cbc_top_tb.sv
// self-checking bench for the bus cycle, hold and interrupt control block
`timescale 1ns/10ps
module cbc_top_tb import cbc_pkg::*;
  ;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  cbc_req_t req_i = '0;
  logic last_cyc_next_i = 1'b0;
  logic halt_i = 1'b0;
  logic irq_set = 1'b0;
  logic irq_clr = 1'b0;
  logic hold_req_i = 1'b0;
  logic irq_i = 1'b0;
  logic [3:0] wait_cyc = 4'h0;
  logic ready_i, req_ready_o, done_o, pc_inhibit_o, irq_enabled_o;
  logic addr_oe_o, data_oe_o, ctrl_oe_o, bus_grant_ack_o;
  logic [7:0] data_in_i, rdata_o, got, wdat;
  cbc_bus_t bus_o;
  logic sel;
  int error_cnt = 0;
  int compares = 0;
  int n_rd, n_wr, n_ack, cyc_cnt = 0;

  cbc_top cbc_top_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .last_cyc_next_i(last_cyc_next_i),
    .halt_i(halt_i), .irq_enable_set_i(irq_set), .irq_enable_clr_i(irq_clr),
    .ready_i(ready_i), .hold_req_i(hold_req_i), .general_irq_request_i(irq_i),
    .data_in_i(data_in_i), .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .pc_inhibit_o(pc_inhibit_o), .irq_enabled_o(irq_enabled_o), .bus_o(bus_o),
    .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o), .ctrl_oe_o(ctrl_oe_o),
    .bus_grant_ack_o(bus_grant_ack_o));
  cbc_mem_model cbc_mem_model_i (.core_clk_i(core_clk_i), .wait_cyc_i(wait_cyc),
    .bus_i(bus_o), .ctrl_oe_i(ctrl_oe_o), .ready_o(ready_i), .data_o(data_in_i));

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // one transfer; valid drops once taken, req_i holds until done
  task automatic xfer(input cbc_op_t op, input logic [15:0] a, input logic [7:0] wd);
    int t;
    n_rd = 0;
    n_wr = 0;
    n_ack = 0;
    @(posedge core_clk_i);
    req_i <= '{addr: a, wdata: wd, io_sel: a[0], op: op};
    req_valid_i <= 1'b1;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    for (t = 0; t < 40 && done_o !== 1'b1; t++) begin
      #1;
      n_rd += !bus_o.rd_n;
      n_wr += !bus_o.wr_n;
      n_ack += !bus_o.ack_n;
      if (bus_o.wr_n && data_oe_o) wdat = bus_o.data;
      if (!(bus_o.rd_n && bus_o.wr_n && bus_o.ack_n)) sel = bus_o.io_sel;
      if (done_o !== 1'b1) @(posedge core_clk_i);
    end
    got = rdata_o;
    chk(done_o, 1'b1, "transfer did not complete");
    chk(sel, a[0], "io select during strobe");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_read();
    for (int w = 0; w < 4; w += 3) begin
      wait_cyc = w[3:0];
      xfer(CBC_OP_READ, 16'h12a0 + w[15:0], 8'h00);
      chk(got, 8'ha0 ^ 8'h3c ^ w[7:0], "read data");
      chk(n_rd > w, 1'b1, "read strobe not stretched");
      chk(n_wr + n_ack, 16'h0, "stray strobe on read");
    end
  endtask
  task automatic t_write();
    wait_cyc = 4'h2;
    xfer(CBC_OP_WRITE, 16'h4401, 8'hc3);
    chk(wdat, 8'hc3, "data at write strobe end");
    chk(n_wr > 2, 1'b1, "write strobe not stretched");
    chk(n_rd, 16'h0, "read strobe on write");
  endtask
  task automatic t_hold();
    @(posedge core_clk_i);
    hold_req_i <= 1'b1;
    tick(2);
    chk(bus_grant_ack_o, 1'b1, "grant missing");
    tick(6);
    chk({addr_oe_o, data_oe_o, ctrl_oe_o}, 3'h0, "bus driven in hold");
    chk(bus_grant_ack_o, 1'b1, "grant dropped early");
    chk(req_ready_o, 1'b0, "transfer offered during hold");
    @(posedge core_clk_i);
    hold_req_i <= 1'b0;
    tick(2);
    chk(bus_grant_ack_o, 1'b0, "grant stuck");
    chk(ctrl_oe_o, 1'b0, "bus retaken before half cycle");
    tick(4);
    chk(ctrl_oe_o, 1'b1, "bus not taken back");
    @(posedge core_clk_i);
    halt_i <= 1'b1;
    tick(3);
    chk(ctrl_oe_o, 1'b0, "strobes driven in halt");
    @(posedge core_clk_i);
    halt_i <= 1'b0;
    tick(3);
  endtask
  task automatic t_irq();
    @(posedge core_clk_i);
    irq_set <= 1'b1;
    irq_i <= 1'b1;
    tick(1);
    @(posedge core_clk_i);
    irq_set <= 1'b0;
    tick(4);
    chk(pc_inhibit_o, 1'b0, "irq taken outside window");
    @(posedge core_clk_i);
    last_cyc_next_i <= 1'b1;
    tick(1);
    @(posedge core_clk_i);
    last_cyc_next_i <= 1'b0;
    tick(3);
    chk(pc_inhibit_o, 1'b1, "irq not accepted");
    chk(irq_enabled_o, 1'b0, "enable not cleared");
    @(posedge core_clk_i);
    irq_i <= 1'b0;
    xfer(CBC_OP_FETCH, 16'h0100, 8'h00);
    chk(n_ack > 0, 1'b1, "no acknowledge strobe");
    chk(n_rd, 16'h0, "read strobe in acknowledge");
    chk(got, 8'h5a, "restart opcode");
    tick(1);
    chk(pc_inhibit_o, 1'b0, "inhibit stuck");
    // software enable and disable, then a request seen while halted
    @(posedge core_clk_i);
    irq_set <= 1'b1;
    tick(1);
    chk(irq_enabled_o, 1'b1, "enable not set");
    @(posedge core_clk_i);
    irq_set <= 1'b0;
    irq_clr <= 1'b1;
    tick(1);
    chk(irq_enabled_o, 1'b0, "enable not cleared by software");
    @(posedge core_clk_i);
    irq_clr <= 1'b0;
    irq_set <= 1'b1;
    halt_i <= 1'b1;
    irq_i <= 1'b1;
    @(posedge core_clk_i);
    irq_set <= 1'b0;
    tick(4);
    chk(pc_inhibit_o, 1'b1, "irq not sampled in halt");
    chk(ctrl_oe_o, 1'b0, "strobes driven in halt");
    @(posedge core_clk_i);
    halt_i <= 1'b0;
    irq_i <= 1'b0;
    xfer(CBC_OP_FETCH, 16'h0200, 8'h00);
    chk(n_ack > 0, 1'b1, "no acknowledge after halt");
    tick(1);
    chk(pc_inhibit_o, 1'b0, "inhibit stuck after halt");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    tick(9);
    chk({addr_oe_o, data_oe_o, ctrl_oe_o}, 3'h0, "bus driven in reset");
    chk(irq_enabled_o, 1'b0, "irq enabled in reset");
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    tick(3);
    t_read();
    t_write();
    t_hold();
    t_irq();
    conclude();
  end
endmodule
